/* rtl/dpram_port_ctrl.sv */
// Host controller for one port of the asynchronous dual-port memory
//
// Summary of operation
// - Strobe stays high whenever the address lines change.
// - Write pulse covers turn-off plus setup, though output enable is held high during writes.
// - Array select held high through token-latch write then read.
// - Token select released an update pulse before reading the latch.
// - Write-to-read spacing honoured before the token result is sampled.
`timescale 1ns/10ps
module dpram_port_ctrl
  import dpram_host_pkg::*;
#(
  parameter bit RIGHT_PORT = 1'b0
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // User request and answer
  input wire logic req_valid,
  input wire req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic token_won,
  output logic mbox_irq,
  // Memory pins
  output pins_t pins,
  input wire logic [DATA_W-1:0] mem_din,
  input wire logic busy_n,
  input wire logic int_n
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_RELEASE = 3'b011,
    ST_UPDATE = 3'b100,
    ST_TREAD = 3'b101,
    ST_DONE = 3'b110
  } state_t;

  typedef struct packed
  {
    state_t st;
    req_t r;
    pins_t p;
    logic ready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic won;
    logic irq;
    logic tload;
    logic [3:0] tcount;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;
  logic t_done;
  logic is_token;
  logic own_mbox;

  pulse_timer u_timer
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(s_q.tload),
    .count(s_q.tcount),
    .done(t_done)
  );

  assign is_token = s_q.r.op[1];
  assign own_mbox = s_q.r.addr == (RIGHT_PORT ? MBOX_RIGHT : MBOX_LEFT);

  function automatic pins_t idle_pins();
    pins_t p;
    p = '0;
    p.array_select_n = 1'b1;
    p.token_latch_select_n = 1'b1;
    p.rw_n = 1'b1;
    p.output_enable_n = 1'b1;
    p.upper_byte_enable_n = 1'b1;
    p.lower_byte_enable_n = 1'b1;
    return p;
  endfunction

  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.tload = 1'b0;
    s_d.irq = !int_n;
    unique case (s_q.st)
      ST_IDLE:
      begin
        s_d.ready = 1'b1;
        if (req_valid && s_q.ready)
        begin
          s_d.ready = 1'b0;
          s_d.r = req;
          s_d.p = idle_pins();
          s_d.p.addr = req.op[1] ? {13'h0, req.addr[2:0]} : req.addr;
          s_d.st = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // Select and strobe fall together: memory outputs stay off
        if (is_token)
          s_d.p.token_latch_select_n = 1'b0;
        else
          s_d.p.array_select_n = 1'b0;
        s_d.p.upper_byte_enable_n = is_token ? 1'b0 : !s_q.r.byte_en[1];
        s_d.p.lower_byte_enable_n = is_token ? 1'b0 : !s_q.r.byte_en[0];
        if (s_q.r.op == OP_READ)
          s_d.p.output_enable_n = 1'b0;
        else
        begin
          s_d.p.rw_n = 1'b0;
          s_d.p.dout_en = 1'b1;
          s_d.p.dout = is_token
            ? {{(DATA_W-1){1'b0}}, s_q.r.op == OP_TOKEN_FREE}
            : s_q.r.wdata;
        end
        s_d.tload = 1'b1;
        s_d.tcount = s_q.r.op == OP_READ ? CNT_RD : CNT_W1;
        s_d.st = ST_STROBE;
      end
      ST_STROBE:
      begin
        // Contention flag holds the access open
        if (t_done && busy_n)
        begin
          s_d.p.rw_n = 1'b1;
          s_d.p.output_enable_n = 1'b1;
          if (s_q.r.op == OP_READ)
            s_d.rdata = mem_din;
          s_d.st = ST_RELEASE;
        end
        else if (t_done)
        begin
          s_d.tload = 1'b1;
          s_d.tcount = 4'h1;
        end
      end
      ST_RELEASE:
      begin
        s_d.p.dout_en = 1'b0;
        s_d.p.array_select_n = 1'b1;
        s_d.p.token_latch_select_n = 1'b1;
        s_d.p.upper_byte_enable_n = 1'b1;
        s_d.p.lower_byte_enable_n = 1'b1;
        if (is_token)
        begin
          s_d.tload = 1'b1;
          s_d.tcount = CNT_UP;
          s_d.st = ST_UPDATE;
        end
        else
          s_d.st = ST_DONE;
      end
      ST_UPDATE:
        if (t_done)
        begin
          // Readback with array select still high
          s_d.p.token_latch_select_n = 1'b0;
          s_d.p.output_enable_n = 1'b0;
          s_d.p.lower_byte_enable_n = 1'b0;
          s_d.tload = 1'b1;
          s_d.tcount = CNT_RD;
          s_d.st = ST_TREAD;
        end
      ST_TREAD:
        if (t_done)
        begin
          s_d.rdata = mem_din;
          s_d.won = !mem_din[0];
          s_d.p = idle_pins();
          s_d.st = ST_DONE;
        end
      ST_DONE:
      begin
        s_d.rvalid = 1'b1;
        s_d.st = ST_IDLE;
      end
      default:
      begin
        s_d.p = idle_pins();
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.p <= idle_pins();
    end
    else
      s_q <= s_d;
  end

  assign req_ready = s_q.ready;
  assign rsp_valid = s_q.rvalid;
  assign rsp_data = s_q.rdata;
  assign token_won = s_q.won;
  assign mbox_irq = s_q.irq;
  assign pins = s_q.p;

  // Checks
  chk_addr_stable:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      !pins.rw_n |-> $stable(pins.addr))
    else $error("address moved during write strobe");
  chk_write_qual:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      !pins.rw_n |-> (!pins.array_select_n || !pins.token_latch_select_n)
        && (!pins.upper_byte_enable_n || !pins.lower_byte_enable_n))
    else $error("write strobe without select and byte enable");
  // A select low ahead of the strobe lets the memory drive our data pins
  chk_select_first:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(pins.rw_n) |-> $past(pins.array_select_n)
        && $past(pins.token_latch_select_n))
    else $error("select fell before write strobe");
  chk_write_width:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(pins.rw_n) |=> !pins.rw_n)
    else $error("write pulse too short");
  chk_token_array:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      !pins.token_latch_select_n |-> pins.array_select_n)
    else $error("array selected during token access");
  chk_token_gap:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_q.st == ST_RELEASE && is_token |=> pins.token_latch_select_n
        && pins.output_enable_n)
    else $error("no update pulse before token read");
  chk_oe_read:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      !pins.output_enable_n |-> pins.rw_n && !pins.dout_en)
    else $error("output enable during write");
  chk_idle_pd:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_q.st == ST_IDLE |-> pins.array_select_n)
    else $error("array selected while idle");
  chk_token_bit:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      pins.dout_en && !pins.token_latch_select_n
        |-> pins.dout[DATA_W-1:1] == '0)
    else $error("token write uses upper data bits");

  cov_write: cover property (@(posedge clk_sys) s_q.st == ST_DONE
    && s_q.r.op == OP_WRITE);
  cov_read: cover property (@(posedge clk_sys) s_q.st == ST_DONE
    && s_q.r.op == OP_READ);
  cov_token: cover property (@(posedge clk_sys) rsp_valid && token_won);
  cov_busy: cover property (@(posedge clk_sys) s_q.st == ST_STROBE
    && !busy_n);
  cov_mbox: cover property (@(posedge clk_sys) rsp_valid && own_mbox
    && s_q.r.op == OP_READ);
endmodule // dpram_port_ctrl

/* rtl/dpram_host_pkg.sv */
// Package: constants and carriers for the dual-port memory port controller
package dpram_host_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int CLK_NS = 40;
  // Timing figures in ns, slowest speed grade
  localparam int T_PWE_NS = 22;
  localparam int T_HZWE_NS = 15;
  localparam int T_SD_NS = 15;
  localparam int T_RC_NS = 25;
  localparam int T_DOE_NS = 13;
  localparam int T_UPDATE_NS = 12;
  localparam int T_WR2RD_NS = 5;
  // Least times round up to whole cycles, at least one
  localparam int WR_PULSE_CYC =
    ((T_HZWE_NS + T_SD_NS > T_PWE_NS ? T_HZWE_NS + T_SD_NS : T_PWE_NS)
     + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_RC_NS + T_DOE_NS + CLK_NS - 1) / CLK_NS;
  localparam int UPDATE_CYC = (T_UPDATE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR2RD_CYC = (T_WR2RD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CNT_W1 = 4'(WR_PULSE_CYC);
  localparam logic [3:0] CNT_RD = 4'(RD_CYC);
  localparam logic [3:0] CNT_UP = 4'(UPDATE_CYC + WR2RD_CYC);
  localparam logic [ADDR_W-1:0] MBOX_RIGHT = 16'hFFFF;
  localparam logic [ADDR_W-1:0] MBOX_LEFT = 16'hFFFE;
  localparam logic [2:0] TOKEN_REQ = 3'h0;

  typedef enum logic [1:0]
  {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_TOKEN_GRAB = 2'b10,
    OP_TOKEN_FREE = 2'b11
  } op_t;

  // User request
  typedef struct packed
  {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] byte_en;
  } req_t;

  // Memory pins, controller side, active-low strobes
  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic array_select_n;
    logic token_latch_select_n;
    logic rw_n;
    logic output_enable_n;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic [DATA_W-1:0] dout;
    logic dout_en;
  } pins_t;
endpackage

/* rtl/pulse_timer.sv */
// Down counter that times one memory phase
`timescale 1ns/10ps
module pulse_timer
  import dpram_host_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [3:0] count,
  output logic done
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = count;
    else if (cnt_q != 4'h0)
      cnt_d = cnt_q - 4'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  end

  assign done = (cnt_q == 4'h1) && !load;
endmodule // pulse_timer

/* sim/dpram_dev_model.sv */
// Behavioural model of one memory port plus its token latches
`timescale 1ns/10ps
module dpram_dev_model
  import dpram_host_pkg::*;
(
  // Controller pins
  input wire pins_t pins,
  output logic [DATA_W-1:0] mem_din,
  output logic int_n,
  // Far port stand-in
  input wire logic [7:0] far_holds,
  input wire logic irq_set
);
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
  logic [7:0] mine;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] last;
  wire logic arr_rd = !pins.array_select_n && !pins.output_enable_n
    && pins.rw_n;
  wire logic tok_rd = !pins.token_latch_select_n
    && !pins.output_enable_n && pins.rw_n;
  wire logic [2:0] ta = pins.addr[2:0];
  initial
  begin
    for (int i = 0; i < 2**ADDR_W; i++)
      mem[i] = '0;
    mine = 8'h00;
    int_n = 1'b1;
    last = '0;
  end
  always @(posedge irq_set) int_n = 1'b0;
  // Writes land at the end of the strobe
  always @(posedge pins.rw_n)
  begin
    if (!pins.array_select_n && !pins.upper_byte_enable_n)
      mem[pins.addr][17:9] = pins.dout[17:9];
    if (!pins.array_select_n && !pins.lower_byte_enable_n)
      mem[pins.addr][8:0] = pins.dout[8:0];
    if (!pins.token_latch_select_n)
      mine[ta] = !pins.dout[0] ? !far_holds[ta] : 1'b0;
  end
  always @(arr_rd, tok_rd, ta, mine, pins.addr)
    rd = arr_rd ? mem[pins.addr] : {DATA_W{!mine[ta]}};
  // Kept only while driving, so release never races the read value
  always @(rd, arr_rd, tok_rd)
    if (arr_rd || tok_rd)
      last = rd;
  always @(negedge arr_rd)
    if (pins.addr == MBOX_LEFT)
      int_n = 1'b1;
  // Released pins show a stale inverse, not a tidy value
  assign mem_din = (arr_rd || tok_rd) ? rd : ~last;
endmodule // dpram_dev_model

/* sim/dpram_port_ctrl_tb.sv */
// Self-checking bench for the port controller
`timescale 1ns/10ps
module dpram_port_ctrl_tb;
  import dpram_host_pkg::*;
  logic clk_sys, sys_rst, req_valid, busy_n, irq_set;
  logic req_ready, rsp_valid, token_won, mbox_irq, int_n;
  logic [DATA_W-1:0] rsp_data, mem_din;
  logic [7:0] far_holds;
  req_t req;
  pins_t pins;
  int n_errors, checks_done, lat;
  dpram_port_ctrl #(.RIGHT_PORT(1'b0)) u_dpram_port_ctrl (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .token_won(token_won), .mbox_irq(mbox_irq), .pins(pins),
    .mem_din(mem_din), .busy_n(busy_n), .int_n(int_n));
  dpram_dev_model u_dpram_dev_model (.pins(pins), .mem_din(mem_din),
    .int_n(int_n), .far_holds(far_holds), .irq_set(irq_set));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [17:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One request; latency counted from the taking edge to rsp_valid
  task automatic do_op(input op_t op, input logic [15:0] a,
    input logic [17:0] d, input logic [1:0] be);
    int n;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, wdata: d, byte_en: be};
    n = 0;
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge clk_sys);
      lat++;
    end
    while (rsp_valid !== 1'b1 && lat < 60);
    check("array select idle", pins.array_select_n, 1'b1);
    check("data pins idle", pins.dout_en, 1'b0);
    if (lat >= 60) n_errors++;
  endtask
  task automatic t_wr_rd();
    do_op(OP_WRITE, 16'hFFFF, 18'h2A5C3, 2'h3);
    check("write latency", 18'(lat), 18'h6);
    do_op(OP_READ, 16'hFFFF, 18'h0, 2'h3);
    check("read data", rsp_data, 18'h2A5C3);
    check("read latency", 18'(lat), 18'h6);
  endtask
  task automatic t_bytes();
    do_op(OP_WRITE, 16'h0000, 18'h3FFFF, 2'h3);
    do_op(OP_WRITE, 16'h0000, 18'h00000, 2'h2);
    do_op(OP_READ, 16'h0000, 18'h0, 2'h3);
    check("upper only", rsp_data, 18'h001FF);
  endtask
  task automatic t_token();
    far_holds <= 8'h08;
    for (int i = 0; i < 8; i++)
    begin
      do_op(OP_TOKEN_GRAB, 16'(i), 18'h0, 2'h3);
      check("token grab", token_won, i != 3);
    end
    do_op(OP_TOKEN_FREE, 16'h0005, 18'h0, 2'h3);
    check("token free", token_won, 1'b0);
    do_op(OP_TOKEN_GRAB, 16'h0005, 18'h0, 2'h3);
    check("token regrab", token_won, 1'b1);
  endtask
  task automatic t_mbox();
    irq_set <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("irq raised", mbox_irq, 1'b1);
    do_op(OP_READ, 16'hFFFF, 18'h0, 2'h3);
    repeat (3) @(posedge clk_sys);
    check("irq kept", mbox_irq, 1'b1);
    do_op(OP_READ, MBOX_LEFT, 18'h0, 2'h3);
    repeat (3) @(posedge clk_sys);
    check("irq cleared", mbox_irq, 1'b0);
  endtask
  task automatic t_busy();
    busy_n <= 1'b0;
    fork
      begin
        repeat (8) @(posedge clk_sys);
        busy_n <= 1'b1;
      end
      do_op(OP_WRITE, 16'h1234, 18'h15A5A, 2'h3);
    join
    check("busy stall", 18'(lat > 6), 18'h1);
    do_op(OP_READ, 16'h1234, 18'h0, 2'h3);
    check("busy data", rsp_data, 18'h15A5A);
  endtask
  initial
  begin
    n_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    busy_n = 1'b1;
    irq_set = 1'b0;
    far_holds = 8'h00;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_wr_rd();
    t_bytes();
    t_token();
    t_mbox();
    t_busy();
    end_sim();
  end
  // Some 19 ops of under 20 cycles each fit well inside this span
  initial
  begin
    #200us;
    n_errors++;
    end_sim();
  end
endmodule // dpram_port_ctrl_tb
